// file: pkg/pfc_pkg.sv
/*
  Shared definitions of the power-factor-correction loop: register byte
  offsets, control field positions, reset values, loop constants, the
  sequencer states and the packed state of the controller.
  Assumes a 32-bit AHB-Lite bus with one word per register.
*/
`default_nettype none
package pfc_pkg;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_ADCCH = 8'h08;
  localparam logic [7:0] OFS_OFFSET = 8'h0c;
  localparam logic [7:0] OFS_RELOAD = 8'h10;
  localparam logic [7:0] OFS_MEAN = 8'h14;
  localparam logic [7:0] OFS_DUTY = 8'h18;
  localparam logic [7:0] OFS_DCTGT = 8'h1c;
  localparam logic [7:0] OFS_OUTER = 8'h20;
  localparam logic [7:0] OFS_OGAIN = 8'h24;
  localparam logic [7:0] OFS_IGAIN = 8'h28;
  localparam logic [7:0] OFS_ODIV = 8'h2c;
  localparam logic [7:0] OFS_TDLY = 8'h30;
  localparam logic [7:0] OFS_INNER = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_FFWD = 8'h3c;
  // ------------------------------------------------------------------
  // Control and status register fields
  // ------------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_PIN = 1;
  localparam int CTRL_OCS = 2;
  localparam int CTRL_ARE = 3;
  localparam int CTRL_HWDIS = 4;
  localparam int CTRL_FSEL = 5;
  localparam int CTRL_SWTRIG = 7;
  localparam int CTRL_CMPEN = 8;
  localparam int STAT_TRIP = 0;
  // ------------------------------------------------------------------
  // Reset values and loop constants
  // ------------------------------------------------------------------
  localparam logic [3:0] IAC_CHANNEL = 4'h6;
  localparam logic [3:0] UDC_CHANNEL = 4'h2;
  localparam logic [3:0] UAC_CHANNEL_RST = 4'h5;
  localparam logic [11:0] ODIV_RST = 12'h001;
  localparam logic [15:0] THR_EIGHTH = 16'h1000;
  localparam logic [15:0] THR_SIXTEENTH = 16'h0800;
  localparam logic [4:0] FILT_LEN_1 = 5'h04;
  localparam logic [4:0] FILT_LEN_2 = 5'h0c;
  localparam logic [4:0] FILT_LEN_3 = 5'h18;
  localparam int MIN_COUNT_SHIFT = 5;
  localparam int DUTY_SHIFT = 15;
  localparam int GAIN_SHIFT = 12;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_DELAY = 3'b001,
    SEQ_IAC = 3'b010,
    SEQ_UAC = 3'b011,
    SEQ_UDC = 3'b100,
    SEQ_CALC = 3'b101
  } pfc_seq_t;

  typedef struct packed {
    pfc_seq_t seq;
    logic [11:0] cnt;
    logic up;
    logic [8:0] dly;
    logic [2:0] uac_div;
    logic [11:0] odiv;
    logic adc_req;
    logic [3:0] adc_chan;
    logic s1;
    logic s2;
    logic filt;
    logic [4:0] fcnt;
    logic trip;
    logic pwm_out;
    logic [8:0] ctrl;
    logic [7:0] cfg;
    logic [3:0] uch;
    logic [15:0] iac_ofs;
    logic [15:0] uac_ofs;
    logic [15:0] ffwd;
    logic [15:0] dc_tgt;
    logic [31:0] ogain;
    logic [31:0] igain;
    logic [11:0] reload;
    logic [11:0] odivr;
    logic [7:0] tdly;
    logic [15:0] ac_current_sample;
    logic [15:0] ac_voltage_sample;
    logic [15:0] dc_bus_voltage_sample;
    logic [15:0] oout;
    logic [15:0] iout;
    logic [15:0] ointeg;
    logic [15:0] iinteg;
    logic prev_below;
    logic [31:0] sum;
    logic [15:0] n;
    logic [15:0] mean;
    logic [11:0] duty;
    logic wr_pend;
    logic [7:0] waddr;
    logic [31:0] hrdata;
    logic hreadyout;
  } pfc_state_t;
endpackage : pfc_pkg
`default_nettype wire

// file: hdl/pfc_loop.sv
/*
  Power-factor-correction controller: carrier counter, ADC sample
  sequencer, outer and inner PI loops, mean of the rectified mains
  voltage, over-current filter and the PWM pin, behind an AHB-Lite slave.
  Assumes the ADC answers each request on the same clock with one
  adc_valid pulse, and that the over-current comparator is asynchronous.
*/
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
// Function
// RULE1: Outer loop PI acts on DC target minus DC bus sample.
// RULE2: Outer loop runs once per outer_loop_divider inner iterations.
// RULE3: Inner loop PI acts on current target minus AC current sample.
// RULE4: Inner loop runs once per carrier period.
// RULE5: Current target is outer output times voltage, feed-forward, gain.
// RULE6: Duty compare value is inner output times reload over 32768.
// RULE7: PWM high while duty exceeds counter, low while below.
// RULE8: PWM reaches the pin only while pin enable is set.
// RULE9: Enabled comparator high forces PWM low.
// RULE10: Comparator input passes a selectable glitch filter.
// RULE11: Clearing pin enable also disables over-current protection.
// RULE12: Hardware averages rectified voltage each mains half period.
// RULE13: Mean is sum of voltage samples over their count.
// RULE14: Period bounds are samples rising through the crossing threshold.
// RULE15: In software mode a trigger closes the period at this sample.
// RULE16: DC bus voltage sampled each carrier period on channel 2.
// RULE17: AC current sampled at overflow each period on channel 6.
// RULE18: Current sample trigger delayed twice the delay setting.
// RULE19: Offset select routes offset writes to current or voltage.
// RULE20: AC voltage sampled every 1, 2, 4 or 8 periods after current.
// RULE21: AC voltage uses channel 5 by default, selectable.
// RULE22: Filter select gives none, 4, 12 or 24 clocks.
// RULE23: Auto restore re-enables PWM once over-current clears.
// RULE24: Carrier counts up to reload, overflows, then counts down.
// RULE25: Valid mean needs at least min_sample_count times 32 samples; the code checks this in hardware mode only.
// RULE26: PI outputs saturate to the signed 16-bit range.
`default_nettype none
module pfc_loop #(
  parameter logic [15:0] CURRENT_GAIN_CONSTANT = 16'h4000
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic adc_req,
  output logic [3:0] adc_chan,
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  input wire logic overcurrent_comparator,
  output logic pwm_out
);
  import pfc_pkg::*;

  // ------------------------------------------------------------------
  // Arithmetic helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] sat16(input logic signed [47:0] x);
    if (x > 48'sd32767) begin
      return 16'h7fff;
    end else if (x < -48'sd32768) begin
      return 16'h8000;
    end
    return x[15:0];
  endfunction : sat16

  // Q15 product, saturated
  function automatic logic [15:0] qmul(input logic [15:0] a,
                                       input logic [15:0] b);
    logic signed [47:0] p;
    p = 48'($signed(a) * $signed(b));
    return sat16(p >>> DUTY_SHIFT);
  endfunction : qmul

  // One PI step; returns {output, new integral}
  function automatic logic [31:0] pi_step(input logic [31:0] gain,
                                          input logic [15:0] refv,
                                          input logic [15:0] fbk,
                                          input logic [15:0] integ);
    logic signed [47:0] err;
    logic signed [47:0] pterm;
    logic signed [47:0] iterm;
    logic [15:0] ni;
    err = 48'($signed(refv)) - 48'($signed(fbk));
    pterm = (err * 48'($signed(gain[15:0]))) >>> GAIN_SHIFT;
    iterm = (err * 48'($signed(gain[31:16]))) >>> GAIN_SHIFT;
    // RULE26: saturated outputs
    ni = sat16(48'($signed(integ)) + iterm);
    return {sat16(pterm + 48'($signed(ni))), ni};
  endfunction : pi_step

  // Sample less its offset, saturated
  function automatic logic [15:0] unbias(input logic [15:0] raw,
                                         input logic [15:0] ofs);
    return sat16(48'($signed(raw)) - 48'($signed(ofs)));
  endfunction : unbias

  // Register read mux, taken in the address phase
  function automatic logic [31:0] rd_mux(input pfc_state_t s,
                                         input logic [7:0] a);
    case (a)
      OFS_CTRL: rd_mux = {23'h0, s.ctrl[CTRL_CMPEN], 1'b0,
                          s.ctrl[CTRL_SWTRIG-1:0]};
      OFS_CFG: rd_mux = {24'h0, s.cfg};
      OFS_ADCCH: rd_mux = {28'h0, s.uch};
      OFS_OFFSET: rd_mux = {16'h0, s.ctrl[CTRL_OCS] ? s.uac_ofs
                                                     : s.iac_ofs};
      OFS_RELOAD: rd_mux = {20'h0, s.reload};
      OFS_MEAN: rd_mux = {16'h0, s.mean};
      OFS_DUTY: rd_mux = {20'h0, s.duty};
      OFS_DCTGT: rd_mux = {16'h0, s.dc_tgt};
      OFS_OUTER: rd_mux = {16'h0, s.oout};
      OFS_OGAIN: rd_mux = s.ogain;
      OFS_IGAIN: rd_mux = s.igain;
      OFS_ODIV: rd_mux = {20'h0, s.odivr};
      OFS_TDLY: rd_mux = {24'h0, s.tdly};
      OFS_INNER: rd_mux = {16'h0, s.iout};
      OFS_STATUS: rd_mux = {4'h0, s.cnt, 7'h0, s.up, 1'b0, s.seq,
                            1'b0, s.pwm_out, s.filt, s.trip};
      OFS_FFWD: rd_mux = {16'h0, s.ffwd};
      default: rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  pfc_state_t st;
  pfc_state_t next_st;
  logic addr_ok;
  logic ovf;
  logic due;
  logic close;
  logic [15:0] v;
  logic [15:0] thr;
  logic [4:0] flen;
  logic [31:0] pr;
  logic [15:0] ctgt;
  logic [26:0] dprod;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    ovf = 1'b0;
    due = 1'b0;
    close = 1'b0;
    v = 16'h0;
    pr = 32'h0;
    ctgt = 16'h0;
    dprod = 27'h0;
    thr = st.cfg[5] ? THR_EIGHTH : THR_SIXTEENTH;
    addr_ok = hsel & htrans[1] & hready;

    // Carrier counter, centre aligned
    // RULE24: up, overflow, down
    if (!st.ctrl[CTRL_EN]) begin
      next_st.cnt = 12'h0;
      next_st.up = 1'b1;
    end else if (st.up) begin
      if (st.cnt >= st.reload) begin
        ovf = 1'b1;
        next_st.up = 1'b0;
        next_st.cnt = (st.cnt == 12'h0) ? 12'h0 : st.cnt - 12'h1;
      end else begin
        next_st.cnt = st.cnt + 12'h1;
      end
    end else if (st.cnt == 12'h0) begin
      next_st.up = 1'b1;
      next_st.cnt = (st.reload != 12'h0) ? 12'h1 : 12'h0;
    end else begin
      next_st.cnt = st.cnt - 12'h1;
    end

    // Sampling sequencer; the ADC request is a one-cycle pulse
    next_st.adc_req = 1'b0;
    unique case (st.seq)
      SEQ_IDLE: begin
        // RULE4: one pass per carrier period
        if (ovf) begin
          // RULE18: delay of twice the setting
          next_st.dly = {st.tdly, 1'b0};
          next_st.seq = SEQ_DELAY;
        end
      end
      SEQ_DELAY: begin
        if (st.dly == 9'h0) begin
          // RULE17: current on fixed channel
          next_st.adc_req = 1'b1;
          next_st.adc_chan = IAC_CHANNEL;
          next_st.seq = SEQ_IAC;
        end else begin
          next_st.dly = st.dly - 9'h1;
        end
      end
      SEQ_IAC: begin
        if (adc_valid) begin
          next_st.ac_current_sample = unbias(adc_data, st.iac_ofs);
          next_st.uac_div = st.uac_div + 3'h1;
          // RULE20: every 1, 2, 4 or 8 periods
          case (st.cfg[7:6])
            2'b00: due = 1'b1;
            2'b01: due = (st.uac_div[0] == 1'b0);
            2'b10: due = (st.uac_div[1:0] == 2'b00);
            default: due = (st.uac_div == 3'b000);
          endcase
          next_st.adc_req = 1'b1;
          // RULE21: selectable voltage channel
          next_st.adc_chan = due ? st.uch : UDC_CHANNEL;
          next_st.seq = due ? SEQ_UAC : SEQ_UDC;
        end
      end
      SEQ_UAC: begin
        if (adc_valid) begin
          next_st.ac_voltage_sample = unbias(adc_data, st.uac_ofs);
          // Rectified value of the mains sample
          v = next_st.ac_voltage_sample[15] ? sat16(-48'($signed(next_st.ac_voltage_sample)))
                              : next_st.ac_voltage_sample;
          next_st.prev_below = (v < thr);
          // RULE14: rising through the threshold
          // RULE12: automatic in hardware mode
          // RULE15: software trigger closes the period
          close = st.ctrl[CTRL_HWDIS] ? st.ctrl[CTRL_SWTRIG]
                                      : ((v > thr) && st.prev_below);
          if (close) begin
            next_st.ctrl[CTRL_SWTRIG] = 1'b0;
            // RULE25: enough samples for a valid mean
            if ((st.n != 16'h0) && (st.ctrl[CTRL_HWDIS] ||
                (st.n >= (16'(st.cfg[4:0]) << MIN_COUNT_SHIFT)))) begin
              // RULE13: sum over count
              next_st.mean = 16'(st.sum / 32'(st.n));
            end
            next_st.sum = 32'(v);
            next_st.n = 16'h1;
          end else begin
            next_st.sum = st.sum + 32'(v);
            next_st.n = (st.n == 16'hffff) ? st.n : st.n + 16'h1;
          end
          next_st.adc_req = 1'b1;
          next_st.adc_chan = UDC_CHANNEL;
          next_st.seq = SEQ_UDC;
        end
      end
      SEQ_UDC: begin
        // RULE16: DC bus every carrier period
        if (adc_valid) begin
          next_st.dc_bus_voltage_sample = adc_data;
          next_st.seq = SEQ_CALC;
        end
      end
      SEQ_CALC: begin
        // RULE2: outer loop at divided rate
        if (st.odiv + 12'h1 >= st.odivr) begin
          next_st.odiv = 12'h0;
          // RULE1: outer voltage loop
          pr = pi_step(st.ogain, st.dc_tgt, st.dc_bus_voltage_sample, st.ointeg);
          next_st.oout = pr[31:16];
          next_st.ointeg = pr[15:0];
        end else begin
          next_st.odiv = st.odiv + 12'h1;
        end
        // RULE5: product of outer, voltage, feed-forward, gain
        ctgt = qmul(qmul(qmul(next_st.oout, st.ac_voltage_sample), st.ffwd),
                    CURRENT_GAIN_CONSTANT);
        // RULE3: inner current loop
        pr = pi_step(st.igain, ctgt, st.ac_current_sample, st.iinteg);
        next_st.iout = pr[31:16];
        next_st.iinteg = pr[15:0];
        // RULE6: duty from inner output and reload
        dprod = pr[31] ? 27'h0 : 27'(pr[30:16]) * 27'(st.reload);
        next_st.duty = dprod[26:15];
        next_st.seq = SEQ_IDLE;
      end
      default: next_st.seq = SEQ_IDLE;
    endcase
    if (!st.ctrl[CTRL_EN]) begin
      next_st.seq = SEQ_IDLE;
    end

    // Comparator synchroniser and glitch filter
    next_st.s1 = overcurrent_comparator;
    next_st.s2 = st.s1;
    // RULE22: filter lengths
    case (st.ctrl[CTRL_FSEL+1:CTRL_FSEL])
      2'b00: flen = 5'h0;
      2'b01: flen = FILT_LEN_1;
      2'b10: flen = FILT_LEN_2;
      default: flen = FILT_LEN_3;
    endcase
    // RULE10: level must hold flen clocks
    if (st.s2 == st.filt) begin
      next_st.fcnt = 5'h0;
    end else if (st.fcnt + 5'h1 >= flen) begin
      next_st.filt = st.s2;
      next_st.fcnt = 5'h0;
    end else begin
      next_st.fcnt = st.fcnt + 5'h1;
    end

    // AHB-Lite data phase writes
    next_st.wr_pend = addr_ok & hwrite;
    next_st.waddr = haddr[7:0];
    if (st.wr_pend) begin
      case (st.waddr)
        OFS_CTRL: begin
          next_st.ctrl[CTRL_SWTRIG-1:0] = hwdata[CTRL_SWTRIG-1:0];
          next_st.ctrl[CTRL_CMPEN] = hwdata[CTRL_CMPEN];
          // Only a one can be written; cleared when consumed
          if (hwdata[CTRL_SWTRIG]) begin
            next_st.ctrl[CTRL_SWTRIG] = 1'b1;
          end
        end
        OFS_CFG: next_st.cfg = hwdata[7:0];
        OFS_ADCCH: next_st.uch = hwdata[3:0];
        OFS_OFFSET: begin
          // RULE19: select steers the offset
          if (st.ctrl[CTRL_OCS]) begin
            next_st.uac_ofs = {1'b0, hwdata[14:0]};
          end else begin
            next_st.iac_ofs = {1'b0, hwdata[14:0]};
          end
        end
        OFS_RELOAD: next_st.reload = hwdata[11:0];
        OFS_DCTGT: next_st.dc_tgt = hwdata[15:0];
        OFS_OGAIN: next_st.ogain = hwdata;
        OFS_IGAIN: next_st.igain = hwdata;
        OFS_ODIV: next_st.odivr = hwdata[11:0];
        OFS_TDLY: next_st.tdly = hwdata[7:0];
        OFS_FFWD: next_st.ffwd = hwdata[15:0];
        default: next_st.ctrl = next_st.ctrl;
      endcase
    end

    // Over-current latch; a clear never beats a live comparator
    // RULE11: protection only with pin enabled
    if (!(st.ctrl[CTRL_CMPEN] && st.ctrl[CTRL_PIN])) begin
      next_st.trip = 1'b0;
    end else if (st.filt) begin
      // RULE9: trip on filtered high
      next_st.trip = 1'b1;
    end else if (st.ctrl[CTRL_ARE] || (st.wr_pend &&
                 st.waddr == OFS_STATUS && hwdata[STAT_TRIP])) begin
      // RULE23: automatic restore when released
      next_st.trip = 1'b0;
    end

    // PWM compare and pin gating
    // RULE7: compare duty with counter
    // RULE8: pin enable gates the pin
    next_st.pwm_out = st.ctrl[CTRL_EN] & st.ctrl[CTRL_PIN] & ~st.trip &
                      (st.duty > st.cnt);

    // Read data for the following data phase
    next_st.hreadyout = 1'b1;
    if (addr_ok && !hwrite) begin
      next_st.hrdata = rd_mux(st, haddr[7:0]);
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.seq <= SEQ_IDLE;
      st.up <= 1'b1;
      st.uch <= UAC_CHANNEL_RST;
      st.odivr <= ODIV_RST;
      st.hreadyout <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign adc_req = st.adc_req;
  assign adc_chan = st.adc_chan;
  assign pwm_out = st.pwm_out;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_pin_gate_low: assert property ( // RULE8
    !st.ctrl[CTRL_PIN] |=> !pwm_out)
    else $error("pwm pin driven while pin disabled");
  a_trip_forces_low: assert property ( // RULE9
    st.trip |=> !pwm_out)
    else $error("pwm high during over-current");
  a_pwm_compare_high: assert property ( // RULE7
    (st.ctrl[CTRL_EN] && st.ctrl[CTRL_PIN] && !st.trip &&
     st.duty > st.cnt) |=> pwm_out)
    else $error("pwm low while duty above counter");
  a_carrier_turn: assert property ( // RULE24
    (st.ctrl[CTRL_EN] && st.up && st.reload != 12'h0 &&
     st.cnt == st.reload) |=> (!st.up && st.cnt == $past(st.cnt) - 12'h1))
    else $error("carrier did not turn at reload");
  a_delay_holds: assert property ( // RULE18
    (st.seq == SEQ_DELAY && st.dly != 9'h0 && st.ctrl[CTRL_EN])
      |=> st.seq == SEQ_DELAY)
    else $error("current sample not delayed");
  a_iac_channel: assert property ( // RULE17
    (adc_req && st.seq == SEQ_IAC) |-> adc_chan == IAC_CHANNEL)
    else $error("current sample on wrong channel");
  a_udc_channel: assert property ( // RULE16
    (adc_req && st.seq == SEQ_UDC) |-> adc_chan == UDC_CHANNEL)
    else $error("dc bus sample on wrong channel");
  a_offset_steer: assert property ( // RULE19
    (st.wr_pend && st.waddr == OFS_OFFSET && !st.ctrl[CTRL_OCS])
      |=> st.iac_ofs == {1'b0, $past(hwdata[14:0])})
    else $error("offset not applied to current");
  a_duty_bound: assert property ( // RULE6
    st.seq == SEQ_CALC |=> st.duty <= $past(st.reload))
    else $error("duty beyond reload");
endmodule : pfc_loop
`default_nettype wire

// file: verif/pfc_adc_model.sv
/*
  Behavioural ADC on the far side of the controller: answers every
  sample request after a latency set by the bench, one value per channel.
  Assumes the same clock as the controller and one request at a time.
*/
`default_nettype none
module pfc_adc_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic adc_req,
  input wire logic [3:0] adc_chan,
  input wire logic [3:0] lat,
  output logic adc_valid,
  output logic [15:0] adc_data
);
  logic busy;
  logic [3:0] wait_cnt;
  logic [3:0] ch;
  // ----------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------
  // Data bus toggles outside a valid pulse so stale data never looks good
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      ch <= 4'h0;
      adc_valid <= 1'b0;
      adc_data <= 16'h0000;
    end else begin
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_req) begin
        busy <= 1'b1;
        wait_cnt <= lat;
        ch <= adc_chan;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        adc_valid <= 1'b1;
        adc_data <= (ch == 4'h6) ? 16'hf000 :
                    (ch == 4'h2) ? 16'h0100 : 16'h2000;
      end
    end
  end
endmodule : pfc_adc_model
`default_nettype wire

// file: verif/test_power_factor_correction_loop.sv
/*
  Self-checking bench of the controller: AHB-Lite register tasks, an ADC
  model, a driven comparator input and cycle counts of the PWM pin.
  Assumes a carrier reload of 64, so one carrier period is 128 cycles.
*/
`default_nettype none
module test_power_factor_correction_loop;
  timeunit 1ns;
  timeprecision 1ps;
  import pfc_pkg::*;
  logic ref_clk, rstn, hsel, hwrite, overcurrent_comparator;
  logic hreadyout, hresp, adc_req, adc_valid, pwm_out;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] adc_chan, lat;
  logic [15:0] adc_data;
  int err_count, compares, cyc, t6, p6, t0, n, k;
  int ch_cnt[16];

  pfc_loop u_pfc_loop (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .adc_req(adc_req),
    .adc_chan(adc_chan), .adc_valid(adc_valid), .adc_data(adc_data),
    .overcurrent_comparator(overcurrent_comparator), .pwm_out(pwm_out));
  pfc_adc_model u_pfc_adc_model (.clk(ref_clk), .rstn(rstn),
    .adc_req(adc_req), .adc_chan(adc_chan), .lat(lat),
    .adc_valid(adc_valid), .adc_data(adc_data));

  // ----------------------------------------------------------------
  // Clock, request log and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Period of current requests is measured between consecutive ones
  // Sampled mid-cycle so clearing and checking at rising edges never race
  always @(negedge ref_clk) begin
    cyc++;
    if (adc_req === 1'b1) begin
      ch_cnt[adc_chan]++;
      if (adc_chan === IAC_CHANNEL) begin
        p6 = cyc - t6;
        t6 = cyc;
      end
    end
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : wt
  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdc
  task automatic pwm_cnt();
    // Let a control write reach the registered pin first
    wt(2);
    k = 0;
    repeat (128) begin
      @(posedge ref_clk);
      k += (pwm_out === 1'b1);
    end
  endtask : pwm_cnt
  task automatic oc_pulse(input int c);
    @(posedge ref_clk) overcurrent_comparator <= 1'b1;
    wt(c);
    overcurrent_comparator <= 1'b0;
    wt(8);
  endtask : oc_pulse
  task automatic clr();
    foreach (ch_cnt[i]) ch_cnt[i] = 0;
  endtask : clr

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, hsel, hwrite, overcurrent_comparator, htrans} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'b010;
    lat = 4'h0;
    wt(2);
    rstn <= 1'b1;
    chk("pwm_rst", 1'b0, pwm_out);
    rdc("adcch_rst", OFS_ADCCH, 32'hf, 32'h5);
    rdc("odiv_rst", OFS_ODIV, 32'hfff, 32'h1);
    rdc("unmapped", 8'h40, 32'hffffffff, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b1, OFS_RELOAD, 32'h40);
    bus(1'b1, OFS_IGAIN, 32'h00001000);
    bus(1'b1, OFS_CTRL, 32'h3);
    wt(512);
    clr();
    wt(1024);
    chk("period", 32'd128, p6);
    chk("iac_req", 32'd8, ch_cnt[6]);
    chk("uac_req", 32'd8, ch_cnt[5]);
    chk("udc_req", 32'd8, ch_cnt[2]);
    lat = 4'h6;
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, OFS_CFG, 32'(s << 6));
      wt(256);
      clr();
      wt(1024);
      chk("uac_interval", 32'(8 >> s), ch_cnt[5]);
    end
    bus(1'b1, OFS_CFG, 32'h0);
    bus(1'b1, OFS_ADCCH, 32'h9);
    wt(256);
    clr();
    wt(1024);
    chk("uac_sel", 32'd8, ch_cnt[9]);
    t0 = t6;
    bus(1'b1, OFS_TDLY, 32'h3);
    wt(256);
    chk("trig_delay", 32'd6, 32'((t6 - t0) % 128));
    rdc("inner", OFS_INNER, 32'hffff, 32'h1000);
    rdc("duty", OFS_DUTY, 32'hfff, 32'h8);
    pwm_cnt();
    chk("pwm_high", 1'b1, k inside {[15:17]});
    bus(1'b1, OFS_CTRL, 32'h1);
    pwm_cnt();
    chk("pin_off", 32'd0, 32'(k));
    bus(1'b1, OFS_CTRL, 32'h163);
    oc_pulse(10);
    rdc("glitch", OFS_STATUS, 32'h1, 32'h0);
    oc_pulse(40);
    rdc("trip", OFS_STATUS, 32'h1, 32'h1);
    pwm_cnt();
    chk("tripped_pwm", 32'd0, 32'(k));
    bus(1'b1, OFS_STATUS, 32'h1);
    pwm_cnt();
    chk("cleared_pwm", 1'b1, k inside {[15:17]});
    bus(1'b1, OFS_CTRL, 32'h16b);
    @(posedge ref_clk) overcurrent_comparator <= 1'b1;
    wt(40);
    pwm_cnt();
    chk("limit_pwm", 32'd0, 32'(k));
    overcurrent_comparator <= 1'b0;
    wt(64);
    pwm_cnt();
    chk("restore_pwm", 1'b1, k inside {[15:17]});
    bus(1'b1, OFS_CTRL, 32'h161);
    oc_pulse(40);
    rdc("no_protect", OFS_STATUS, 32'h1, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h13);
    bus(1'b1, OFS_CTRL, 32'h93);
    wt(512);
    rdc("mean", OFS_MEAN, 32'hffff, 32'h2000);
    bus(1'b1, OFS_OGAIN, 32'h00001000);
    bus(1'b1, OFS_DCTGT, 32'h0300);
    bus(1'b1, OFS_FFWD, 32'h7fff);
    wt(256);
    rdc("outer", OFS_OUTER, 32'hffff, 32'h0200);
    rdc("ctgt", OFS_INNER, 32'hffff, 32'h103f);
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_OFFSET, 32'hc123);
    rdc("iac_ofs", OFS_OFFSET, 32'hffff, 32'h4123);
    bus(1'b1, OFS_CTRL, 32'h5);
    rdc("uac_ofs", OFS_OFFSET, 32'hffff, 32'h0);
    wrap_up();
  end
endmodule : test_power_factor_correction_loop
`default_nettype wire
